/* File: include/alarm_cfg.svh */
// Purpose: named constants of the motor drive alarm manager
// Assumes: 250 MHz aclk
// Notes: definitions only
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

`define CLK_MHZ 250
`define OVERLOAD_MS 5000
`define BLINK_HALF_MS 250
`define BLINK_PAUSE_SLOTS 5'h6
`define BOOT_WAIT 3'h5
`define PIN_W 19
`define P_OVERLOAD 0
`define P_SENSOR 1
`define P_MAIN_PWR 2
`define P_OVERVOLT 3
`define P_UNDERVOLT 4
`define P_OVERSPEED 5
`define P_OVERCURR 6
`define P_MEMFAULT 7
`define P_REGEN 8
`define P_EXTFAULT 9
`define P_FWD 10
`define P_REV 11
`define P_NETDISC 12
`define P_RUNNING 13
`define P_ALMRST 14
`define P_BAUD_LO 15
`define P_BAUD_HI 18
`define BAUD_MAX 4'h4
`define CODE_OVERCURR 8'h20
`define CODE_OVERVOLT 8'h22
`define CODE_UNDERVOLT 8'h25
`define CODE_SENSOR 8'h28
`define CODE_OVERLOAD 8'h30
`define CODE_OVERSPEED 8'h31
`define CODE_MEMFAULT 8'h41
`define CODE_INIT_SENSOR 8'h42
`define CODE_INHIBIT 8'h46
`define CODE_REGEN 8'h51
`define CODE_EXTSTOP 8'h6e
`define CODE_NETBUS 8'h81
`define CODE_BAUD 8'h83
`define CODE_SERIAL 8'h84
`define HIST_DEPTH 4'ha
`define ERR_THR_RST 4'h3
`define ERR_THR_MAX 4'ha
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CONFIG 8'h08
`define REG_HSEL 8'h0c
`define REG_HDATA 8'h10
`define CTRL_RST 0
`define CTRL_HCLR 1
`define CTRL_INIT_EN 2
`define CTRL_EXT_EN 3
`define CTRL_ERR_CLR 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: include/alarm_pkg.sv */
// Purpose: state types of the alarm manager and its history store
// Assumes: alarm_cfg.svh constants
// Notes: each module keeps all of its state in one struct
`default_nettype none
`include "alarm_cfg.svh"
package alarm_pkg;
    typedef struct packed {
        logic [`PIN_W-1:0] s1, s2, s3, pin;
        logic rst_prev;
        logic [7:0] code;
        logic active, inhibit, ovl_long, comm_err;
        logic [30:0] ovl_cnt;
        logic [3:0] err_cnt, err_thr, hsel;
        logic init_en, ext_en;
        logic [2:0] boot;
        logic [26:0] div;
        logic [4:0] slot;
        logic led, fault_out, motor_stop, warn;
        logic awready, wready, bvalid, aw_have, w_have, wstb;
        logic [1:0] bresp, rresp;
        logic [7:0] waddr;
        logic [31:0] wdata, rdata;
        logic arready, rvalid;
        logic push, hclr;
        logic [7:0] push_code;
    } mgr_state_t;

    typedef struct packed {
        logic [9:0][7:0] ent;
        logic [3:0] cnt;
    } hist_state_t;
endpackage
`default_nettype wire

/* File: include/history_if.sv */
// Purpose: link between the alarm manager and its history store
// Assumes: one clock domain
// Notes: push and clear are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface history_if;
    logic push;
    logic [7:0] push_code;
    logic clear;
    logic [3:0] rd_idx;
    logic [7:0] rd_code;
    logic rd_ok;
    logic [3:0] count;
    modport mgr (output push, push_code, clear, rd_idx,
                 input rd_code, rd_ok, count);
    modport store (input push, push_code, clear, rd_idx,
                   output rd_code, rd_ok, count);
endinterface
`default_nettype wire

/* File: hw/alarm_history.sv */
// Purpose: ten-entry alarm code history, newest at index 0
// Assumes: push and clear never in the same cycle as each other matter
// Notes: flops stand in for the non-volatile array; clear wins over push
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg.svh"
module alarm_history (
    input wire logic aclk,
    input wire logic aresetn,
    history_if.store hist
);
    alarm_pkg::hist_state_t q, d;

    always_comb begin
        d = q;
        if (hist.clear) begin
            d.cnt = 4'h0;
        end else if (hist.push) begin
            d.ent = {q.ent[8:0], hist.push_code};
            if (q.cnt != `HIST_DEPTH) begin
                d.cnt = q.cnt + 4'h1;
            end
        end
        hist.count = q.cnt;
        hist.rd_ok = hist.rd_idx < q.cnt;
        hist.rd_code = hist.rd_ok ? q.ent[hist.rd_idx] : 8'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    hist_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        q.cnt <= `HIST_DEPTH) else $error("history count above depth");
endmodule
`default_nettype wire

/* File: hw/motor_drive_alarm_manager.sv */
// Purpose: alarm detection, latching, indication and reset for a motor drive
// Assumes: detector pins asynchronous; serial commands arrive as AXI writes
// Notes: first alarm wins and is held until a permitted reset
`timescale 1ns/1ps
`default_nettype none
`include "alarm_cfg.svh"
module motor_drive_alarm_manager #(
    parameter int unsigned OVERLOAD_CYCLES = `OVERLOAD_MS * `CLK_MHZ * 1000,
    parameter int unsigned BLINK_CYCLES = `BLINK_HALF_MS * `CLK_MHZ * 1000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic overload_in,
    input wire logic sensor_loss_in,
    input wire logic main_power_in,
    input wire logic overvoltage_in,
    input wire logic undervoltage_in,
    input wire logic overspeed_in,
    input wire logic overcurrent_in,
    input wire logic memory_fault_in,
    input wire logic regen_hot_in,
    input wire logic external_fault_input,
    input wire logic forward_run_input,
    input wire logic reverse_run_input,
    input wire logic net_disconnect_in,
    input wire logic motor_running_in,
    input wire logic alarm_reset_input,
    input wire logic [3:0] baud_select_switch,
    input wire logic serial_error,
    input wire logic serial_good,
    output logic fault_output,
    output logic motor_stop,
    output logic power_fault_indicator,
    output logic warning_output
);
    alarm_pkg::mgr_state_t q, d;
    history_if hist ();

    alarm_history u_history (
        .aclk(aclk),
        .aresetn(aresetn),
        .hist(hist)
    );

    function automatic logic [4:0] blinks(input logic [7:0] c);
        case (c)
            `CODE_OVERLOAD: blinks = 5'h2;
            `CODE_SENSOR, `CODE_INIT_SENSOR: blinks = 5'h3;
            `CODE_OVERVOLT: blinks = 5'h4;
            `CODE_UNDERVOLT: blinks = 5'h5;
            `CODE_OVERSPEED: blinks = 5'h6;
            `CODE_OVERCURR: blinks = 5'h7;
            `CODE_MEMFAULT: blinks = 5'h8;
            `CODE_REGEN: blinks = 5'h9;
            `CODE_EXTSTOP: blinks = 5'ha;
            `CODE_INHIBIT: blinks = 5'hb;
            default: blinks = 5'hc;
        endcase
    endfunction

    function automatic logic locked(input logic [7:0] c);
        locked = (c == `CODE_MEMFAULT) || (c == `CODE_BAUD);
    endfunction

    // cause still present for a given code; also used for detection
    function automatic logic cause(input logic [7:0] c,
                                   input alarm_pkg::mgr_state_t s);
        logic [3:0] baud;
        baud = s.pin[`P_BAUD_HI:`P_BAUD_LO];
        case (c)
            `CODE_OVERCURR: cause = s.pin[`P_OVERCURR];
            `CODE_OVERVOLT: cause = s.pin[`P_OVERVOLT];
            `CODE_UNDERVOLT: cause = s.pin[`P_UNDERVOLT];
            `CODE_MEMFAULT: cause = s.pin[`P_MEMFAULT];
            `CODE_BAUD: cause = baud > `BAUD_MAX;
            `CODE_SENSOR: cause = s.pin[`P_SENSOR] && s.pin[`P_MAIN_PWR];
            `CODE_INIT_SENSOR:
                cause = s.pin[`P_SENSOR] && !s.pin[`P_MAIN_PWR];
            `CODE_OVERSPEED: cause = s.pin[`P_OVERSPEED];
            `CODE_OVERLOAD: cause = s.ovl_long;
            `CODE_REGEN: cause = s.pin[`P_REGEN];
            `CODE_EXTSTOP: cause = s.ext_en && !s.pin[`P_EXTFAULT];
            // enable read live: it resets to zero, so a boot-time gate is dead
            `CODE_INHIBIT: cause = s.inhibit && s.init_en;
            `CODE_NETBUS: cause = s.pin[`P_NETDISC] && s.pin[`P_RUNNING];
            `CODE_SERIAL: cause = s.err_cnt >= s.err_thr;
            default: cause = 1'b0;
        endcase
    endfunction

    logic [`PIN_W-1:0] pins_raw;
    logic [7:0] new_code;
    logic new_hit, rst_req, wr_go;

    assign pins_raw = {baud_select_switch, alarm_reset_input,
        motor_running_in, net_disconnect_in, reverse_run_input,
        forward_run_input, external_fault_input, regen_hot_in,
        memory_fault_in, overcurrent_in, overspeed_in, undervoltage_in,
        overvoltage_in, main_power_in, sensor_loss_in, overload_in};

    always_comb begin
        d = q;
        new_hit = 1'b1;
        // severe electrical faults take priority over the rest
        if (cause(`CODE_OVERCURR, q)) new_code = `CODE_OVERCURR;
        else if (cause(`CODE_OVERVOLT, q)) new_code = `CODE_OVERVOLT;
        else if (cause(`CODE_UNDERVOLT, q)) new_code = `CODE_UNDERVOLT;
        else if (cause(`CODE_MEMFAULT, q)) new_code = `CODE_MEMFAULT;
        else if (cause(`CODE_BAUD, q)) new_code = `CODE_BAUD;
        else if (cause(`CODE_SENSOR, q)) new_code = `CODE_SENSOR;
        else if (cause(`CODE_INIT_SENSOR, q)) new_code = `CODE_INIT_SENSOR;
        else if (cause(`CODE_OVERSPEED, q)) new_code = `CODE_OVERSPEED;
        else if (cause(`CODE_OVERLOAD, q)) new_code = `CODE_OVERLOAD;
        else if (cause(`CODE_REGEN, q)) new_code = `CODE_REGEN;
        else if (cause(`CODE_EXTSTOP, q)) new_code = `CODE_EXTSTOP;
        else if (cause(`CODE_INHIBIT, q)) new_code = `CODE_INHIBIT;
        else if (cause(`CODE_NETBUS, q)) new_code = `CODE_NETBUS;
        else if (cause(`CODE_SERIAL, q)) new_code = `CODE_SERIAL;
        else begin
            new_hit = 1'b0;
            new_code = 8'h00;
        end

        // pin synchroniser: a change counts once stages two and three agree
        d.s1 = pins_raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < `PIN_W; i++) begin
            if (q.s2[i] == q.s3[i]) d.pin[i] = q.s3[i];
        end
        d.rst_prev = q.pin[`P_ALMRST];

        if (q.pin[`P_OVERLOAD]) begin
            if (!q.ovl_long) d.ovl_cnt = q.ovl_cnt + 31'h1;
            if (q.ovl_cnt >= 31'(OVERLOAD_CYCLES - 1)) d.ovl_long = 1'b1;
        end else begin
            d.ovl_cnt = 31'h0;
            d.ovl_long = 1'b0;
        end

        if (serial_error && q.err_cnt != 4'hf) d.err_cnt = q.err_cnt + 4'h1;
        else if (serial_good) d.err_cnt = 4'h0;

        // run inputs sampled once, after the synchroniser has settled
        if (q.boot != `BOOT_WAIT) d.boot = q.boot + 3'h1;
        if (q.boot == `BOOT_WAIT - 3'h1) begin
            d.inhibit = q.pin[`P_FWD] || q.pin[`P_REV];
        end else if (!(q.pin[`P_FWD] || q.pin[`P_REV])) begin
            d.inhibit = 1'b0;
        end

        d.warn = q.pin[`P_OVERLOAD] || (q.err_cnt != 4'h0);

        // AXI4-Lite slave; commands from the serial link land here too
        d.push = 1'b0;
        d.hclr = 1'b0;
        rst_req = q.rst_prev && !q.pin[`P_ALMRST];
        wr_go = q.aw_have && q.w_have && !q.bvalid;
        if (awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.waddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = wdata;
            d.wstb = wstrb[0];
        end
        if (bready && q.bvalid) d.bvalid = 1'b0;
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            if (q.waddr == `REG_CTRL) begin
                if (q.wstb) begin
                    rst_req = rst_req || q.wdata[`CTRL_RST];
                    d.hclr = q.wdata[`CTRL_HCLR];
                    d.init_en = q.wdata[`CTRL_INIT_EN];
                    d.ext_en = q.wdata[`CTRL_EXT_EN];
                    if (q.wdata[`CTRL_ERR_CLR]) d.comm_err = 1'b0;
                end
            end else if (q.waddr == `REG_CONFIG) begin
                if (q.wdata[3:0] == 4'h0 || q.wdata[3:0] > `ERR_THR_MAX) begin
                    d.bresp = `RESP_SLVERR;
                end else if (q.wstb) begin
                    d.err_thr = q.wdata[3:0];
                end
            end else if (q.waddr == `REG_HSEL) begin
                if (q.wstb) d.hsel = q.wdata[3:0];
            end else begin
                d.bresp = `RESP_SLVERR;
            end
        end
        if (rready && q.rvalid) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            d.rdata = 32'h0;
            if (araddr == `REG_CTRL) begin
                d.rdata[`CTRL_INIT_EN] = q.init_en;
                d.rdata[`CTRL_EXT_EN] = q.ext_en;
            end else if (araddr == `REG_STATUS) begin
                d.rdata = {16'h0, hist.count, q.comm_err, q.warn,
                    q.active, q.inhibit, q.code};
            end else if (araddr == `REG_CONFIG) begin
                d.rdata[3:0] = q.err_thr;
            end else if (araddr == `REG_HSEL) begin
                d.rdata[3:0] = q.hsel;
            end else if (araddr == `REG_HDATA) begin
                d.rdata[7:0] = hist.rd_code;
                if (!hist.rd_ok) d.rresp = `RESP_SLVERR;
            end else begin
                d.rresp = `RESP_SLVERR;
            end
        end
        // a refused request raises the flag; set wins over a same-cycle clear
        if ((wr_go && d.bresp != `RESP_OKAY)
            || (arvalid && q.arready && d.rresp != `RESP_OKAY)) begin
            d.comm_err = 1'b1;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;

        // alarm latch: only the first alarm is held
        if (!q.active && new_hit) begin
            d.active = 1'b1;
            d.code = new_code;
            d.push = 1'b1;
            d.push_code = new_code;
            d.slot = 5'h0;
            d.div = 27'h0;
        end else if (q.active && rst_req && !locked(q.code)
                     && !cause(q.code, q)) begin
            d.active = 1'b0;
        end

        // indicator divider: one enable per half blink period
        if (q.div == 27'(BLINK_CYCLES - 1) && (q.active || !new_hit)) begin
            d.div = 27'h0;
            if (q.slot >= 5'(blinks(q.code) * 2) + `BLINK_PAUSE_SLOTS - 5'h1) begin
                d.slot = 5'h0;
            end else begin
                d.slot = q.slot + 5'h1;
            end
        end else if (!(!q.active && new_hit)) begin
            d.div = q.div + 27'h1;
        end
        d.led = d.active ? (d.slot < 5'(blinks(d.code) * 2) && !d.slot[0])
            : 1'b1;
        d.fault_out = !d.active;
        d.motor_stop = d.active;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.err_thr <= `ERR_THR_RST;
            q.led <= 1'b1;
            q.fault_out <= 1'b1;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hist.push = q.push;
    assign hist.push_code = q.push_code;
    assign hist.clear = q.hclr;
    assign hist.rd_idx = q.hsel;
    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign fault_output = q.fault_out;
    assign motor_stop = q.motor_stop;
    assign power_fault_indicator = q.led;
    assign warning_output = q.warn;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    fault_stop_a: assert property ($rose(q.active) |-> !fault_output
        && motor_stop && power_fault_indicator && q.slot == 5'h0)
        else $error("alarm outputs not set together");
    blink_gap_a: assert property (q.active
        && q.slot >= 5'(blinks(q.code) * 2) |-> !power_fault_indicator)
        else $error("indicator lit during pause");
    pin_hold_a: assert property (q.active && !locked(q.code)
        && q.pin[`P_ALMRST] && $past(q.pin[`P_ALMRST]) && !wr_go
        |=> q.active) else $error("reset taken without falling edge");
    locked_alarm_a: assert property (q.active && locked(q.code)
        |=> q.active && $stable(q.code))
        else $error("locked alarm released");
    hist_push_a: assert property ($rose(q.active) |-> q.push
        && q.push_code == q.code ##1 !q.push)
        else $error("alarm not pushed to history once");
    overload_time_a: assert property ($rose(q.active)
        && q.code == `CODE_OVERLOAD |-> $past(q.ovl_long))
        else $error("overload raised early");
    serial_thr_a: assert property ($rose(q.active)
        && q.code == `CODE_SERIAL |-> $past(q.err_cnt) >= $past(q.err_thr))
        else $error("serial alarm below threshold");
    inhibit_en_a: assert property ($rose(q.active)
        && q.code == `CODE_INHIBIT |-> $past(q.init_en))
        else $error("inhibit alarm while disabled");
    ext_assign_a: assert property ($rose(q.active)
        && q.code == `CODE_EXTSTOP |-> $past(q.ext_en))
        else $error("external stop while unassigned");
    cause_hold_a: assert property (q.active && cause(q.code, q)
        |=> q.active) else $error("alarm cleared with cause present");
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
// Purpose: master controller model, serial commands as AXI4-Lite
// Assumes: one write and one read at most under way
// Notes: waits without a cycle count; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (!ta && awready) begin
                ta = 1'h1;
                awvalid <= 1'h0;
            end
            if (!tw && wready) begin
                tw = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench of the motor drive alarm manager
// Assumes: short overload and blink counts by parameter
// Notes: detector causes driven through one vector c
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fo, ms, ind, wrn;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, baud = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic [9:0] c = 10'h0;
    logic mp = 1'h1, rst_in = 1'h0, s_err = 1'h0, s_good = 1'h0;
    logic [1:0] run = 2'h0;
    int miscompares = 0, n_compared = 0;
    logic [7:0] codes [10] = '{8'h30, 8'h22, 8'h25, 8'h31, 8'h20,
                               8'h51, 8'h28, 8'h81, 8'h6e, 8'h42};
    int blinks [10] = '{2, 4, 5, 6, 7, 9, 3, 12, 10, 3};
    always #2 aclk = ~aclk;
    host_model m (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    motor_drive_alarm_manager #(.OVERLOAD_CYCLES(20), .BLINK_CYCLES(4)) DUT (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready,
        .overload_in(c[0]), .overvoltage_in(c[1]), .undervoltage_in(c[2]),
        .overspeed_in(c[3]), .overcurrent_in(c[4]), .regen_hot_in(c[5]),
        .sensor_loss_in(c[6]), .net_disconnect_in(c[7]),
        .motor_running_in(c[7]), .external_fault_input(!c[8]),
        .memory_fault_in(c[9]), .main_power_in(mp),
        .forward_run_input(run[0]),
        .reverse_run_input(run[1]), .alarm_reset_input(rst_in),
        .baud_select_switch(baud), .serial_error(s_err),
        .serial_good(s_good), .fault_output(fo), .motor_stop(ms),
        .power_fault_indicator(ind), .warning_output(wrn));
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task pulse_rst; // outside party asserts then releases
        rst_in <= 1'h1;
        cyc(10);
        check(fo, 1'h0);
        rst_in <= 1'h0;
    endtask
    task t_codes;
        int n;
        logic p;
        c <= 10'h100;
        cyc(20);
        check(fo, 1'h1);
        c <= 10'h0;
        // let the fault pin settle before assigning the function
        cyc(8);
        m.wr(8'h00, 32'h8, r);
        for (int i = 0; i < 10; i++) begin
            mp <= (i != 9);
            c <= (i == 9) ? 10'h40 : 10'h1 << i;
            cyc(40);
            check(fo, 1'h0);
            check(ms, 1'h1);
            m.rd(8'h04, d, r);
            check(d[7:0], codes[i]);
            n = 0;
            p = ind;
            repeat (4 * (2 * blinks[i] + 6)) begin
                @(posedge aclk);
                if (ind && !p) n++;
                p = ind;
            end
            check(n, blinks[i]);
            if (i == 4) begin
                m.wr(8'h00, 32'h9, r);
                cyc(8);
                check(fo, 1'h0);
            end
            c <= 10'h0;
            mp <= 1'h1;
            cyc(6);
            if (i % 2) pulse_rst();
            else m.wr(8'h00, 32'h9, r);
            cyc(8);
            check(fo, 1'h1);
            m.rd(8'h10, d, r);
            check(d[7:0], codes[i]);
        end
        $display("done alarm codes");
    endtask
    task t_serial;
        m.rd(8'h08, d, r);
        check(d[3:0], 4'h3);
        repeat (3) begin
            check(fo, 1'h1);
            s_err <= 1'h1;
            cyc(1);
            s_err <= 1'h0;
            cyc(3);
        end
        m.rd(8'h04, d, r);
        check(d[7:0], 8'h84);
        check(wrn, 1'h1);
        s_good <= 1'h1;
        cyc(1);
        s_good <= 1'h0;
        m.wr(8'h00, 32'h9, r);
        m.rd(8'h04, d, r);
        check({d[15:12], d[9]}, 5'h14);
        check(wrn, 1'h0);
        m.wr(8'h0c, 32'h9, r);
        m.rd(8'h10, d, r);
        check(d[7:0], 8'h22);
        m.wr(8'h08, 32'h0, r);
        check(r, 2'h2);
        m.wr(8'h20, 32'h1, r);
        check(r, 2'h2);
        m.rd(8'h24, d, r);
        check(r, 2'h2);
        m.rd(8'h04, d, r);
        check(d[11], 1'h1);
        m.wr(8'h00, 32'h1a, r);
        m.rd(8'h04, d, r);
        check(d[15:12], 4'h0);
        check(d[11], 1'h0);
        $display("done serial and history");
    endtask
    task t_power;
        c <= 10'h200;
        cyc(20);
        c <= 10'h0;
        cyc(6);
        pulse_rst();
        m.wr(8'h00, 32'h9, r);
        m.rd(8'h04, d, r);
        check(d[7:0], 8'h41);
        aresetn <= 1'h0;
        cyc(6);
        aresetn <= 1'h1;
        cyc(2);
        check(fo, 1'h1);
        baud <= 4'h7;
        cyc(20);
        m.wr(8'h00, 32'h9, r);
        m.rd(8'h04, d, r);
        check(d[7:0], 8'h83);
        baud <= 4'h0;
        run <= 2'h2;
        aresetn <= 1'h0;
        cyc(6);
        aresetn <= 1'h1;
        cyc(12);
        check(fo, 1'h1);
        m.wr(8'h00, 32'h4, r);
        cyc(4);
        m.rd(8'h04, d, r);
        check(d[8:0], 9'h146);
        check(fo, 1'h0);
        run <= 2'h0;
        cyc(8);
        m.wr(8'h00, 32'h1, r);
        cyc(2);
        check(fo, 1'h1);
        $display("done power cycle");
    endtask
    initial begin
        cyc(6);
        aresetn <= 1'h1;
        cyc(2);
        check({fo, ms, ind}, 3'h5);
        t_codes();
        t_serial();
        t_power();
        stop_test();
    end
    initial begin
        cyc(40000);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
